// ==== hdl/bdm_map.sv ====
`timescale 1ns/10ps
module bdm_map
  import bdm_pkg::*;
#(
  parameter int PC_W = BDM_PC_W
)(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // access from cpu
  input wire bdm_pkg::bdm_acc_t acc,
  output logic [7:0] rdata,
  // auxiliary page strobes
  output logic fpage_sel,
  output logic spage_sel,
  output logic [6:0] aux_ofs,
  input wire logic [7:0] aux_rdata,
  // external sfr strobes (other r-page registers)
  output logic sfr_sel,
  output logic [6:0] sfr_ofs,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // program counter control
  input wire bdm_pkg::bdm_pcop_t pcop,
  output logic [10:0] pc,
  output logic push,
  output logic [10:0] push_addr,
  // timer0 sources
  input wire logic instruction_clock,
  input wire logic ext_timer0_clock_pin,
  input wire logic low_osc_tick,
  input wire logic timer0_mode_bits,
  input wire logic cfg_low_osc
);
  logic [7:0] gpr0 [96];
  logic [7:0] gpr1 [32];
  logic [7:0] status;
  logic [7:0] fptr;
  logic [2:0] pc_high_buffer;
  logic [7:0] next_status;
  logic [7:0] next_fptr;
  logic [2:0] next_pchb;
  logic [10:0] next_pc;
  logic next_push;
  logic [10:0] next_push_addr;
  logic [7:0] next_rdata;
  logic [1:0] bank;
  logic [6:0] ofs;
  logic rpage;
  logic g0_hit;
  logic g1_hit;
  logic [6:0] g0_idx;
  logic [4:0] g1_idx;
  logic [7:0] tcount;
  logic tload;
  bdm_tsrc_t tsrc;

  assign bank = status[7:6];
  // aux pages only for their instructions
  assign rpage = acc.valid && acc.space == BDM_SP_RPAGE;

  always_comb begin
    ofs = acc.opcode_ofs;
    if (rpage && acc.indirect) begin
      ofs = fptr[6:0];
    end
    if (rpage && !acc.indirect && acc.opcode_ofs == BDM_OFS_INDIRECT_ACCESS_PORT) begin
      ofs = fptr[6:0];
    end
  end

  always_comb begin
    g0_hit = 1'b0;
    g1_hit = 1'b0;
    g0_idx = ofs - BDM_GPR_LO;
    g1_idx = 5'(ofs - BDM_GPR_LO);
    if (rpage && ofs >= BDM_GPR_LO) begin
      if (ofs <= BDM_B1_TOP && (bank == BDM_BANK1 || bank == BDM_BANK3)) begin
        g1_hit = 1'b1;
      end else begin
        g0_hit = 1'b1;
      end
    end
  end

  always_comb begin
    sfr_sel = 1'b0;
    sfr_ofs = ofs;
    if (rpage && ofs <= BDM_SFR_TOP) begin
      unique case (ofs)
        BDM_OFS_INDIRECT_ACCESS_PORT, BDM_OFS_TMR, BDM_OFS_PCLO, BDM_OFS_STAT,
        BDM_OFS_FPTR, BDM_OFS_PCHB: sfr_sel = 1'b0;
        BDM_OFS_NONE7, BDM_OFS_NONED, BDM_OFS_NONE1D,
        BDM_OFS_NONE1E: sfr_sel = 1'b0;
        default: sfr_sel = 1'b1;
      endcase
    end
  end

  assign fpage_sel = acc.valid && (acc.space == BDM_SP_FPAGE_WR ||
                                   acc.space == BDM_SP_FPAGE_RD);
  assign spage_sel = acc.valid && (acc.space == BDM_SP_SPAGE_WR ||
                                   acc.space == BDM_SP_SPAGE_RD);
  assign aux_ofs = acc.opcode_ofs;

  always_comb begin
    tsrc = BDM_SRC_INST;
    if (timer0_mode_bits) begin
      tsrc = cfg_low_osc ? BDM_SRC_LOSC : BDM_SRC_PIN;
    end
  end

  assign tload = rpage && acc.wr && ofs == BDM_OFS_TMR;

  bdm_timer0 u_timer0 (
    .mclk(mclk),
    .reset_n(reset_n),
    .instruction_clock(instruction_clock),
    .ext_timer0_clock_pin(ext_timer0_clock_pin),
    .low_osc_tick(low_osc_tick),
    .src(tsrc),
    .load(tload),
    .load_data(acc.wdata),
    .count(tcount)
  );

  // read mux
  always_comb begin
    next_rdata = BDM_ZERO;
    if (fpage_sel || spage_sel) begin
      next_rdata = aux_rdata;
    end else if (g0_hit) begin
      next_rdata = gpr0[g0_idx];
    end else if (g1_hit) begin
      next_rdata = gpr1[g1_idx];
    end else if (rpage) begin
      unique case (ofs)
        BDM_OFS_TMR: next_rdata = tcount;
        BDM_OFS_PCLO: next_rdata = pc[7:0];
        BDM_OFS_STAT: next_rdata = status;
        BDM_OFS_FPTR: next_rdata = fptr;
        BDM_OFS_INDIRECT_ACCESS_PORT, BDM_OFS_NONE7, BDM_OFS_NONED, BDM_OFS_NONE1D,
        BDM_OFS_NONE1E: next_rdata = BDM_ZERO;
        BDM_OFS_PCHB: next_rdata = BDM_ZERO;
        default: next_rdata = sfr_hit ? sfr_rdata : BDM_ZERO;
      endcase
    end
  end

  // core registers and pc
  always_comb begin
    next_status = status;
    next_fptr = fptr;
    next_pchb = pc_high_buffer;
    next_pc = pc;
    next_push = 1'b0;
    next_push_addr = push_addr;
    if (rpage && acc.wr && ofs == BDM_OFS_STAT) begin
      next_status = acc.wdata;
    end
    if (rpage && acc.wr && ofs == BDM_OFS_FPTR) begin
      next_fptr = acc.wdata;
    end
    if (rpage && acc.wr && ofs == BDM_OFS_PCHB) begin
      next_pchb = acc.wdata[2:0];
    end
    if (pcop.long_jump_instr) begin
      next_pc = pcop.target;
    end else if (pcop.long_call_instr) begin
      next_pc = pcop.target;
      next_push = 1'b1;
      next_push_addr = pc + 11'h001;
    end else if (rpage && acc.wr && ofs == BDM_OFS_PCLO) begin
      next_pc = {pc_high_buffer, acc.wdata};
    end else if (pcop.step) begin
      next_pc = pc + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status <= BDM_STAT_RST;
      fptr <= BDM_ZERO;
      pc_high_buffer <= BDM_PCHB_RST;
      pc <= {BDM_PCHB_RST, BDM_PCLO_RST};
      push <= 1'b0;
      push_addr <= {BDM_PCHB_RST, BDM_PCLO_RST};
      rdata <= BDM_ZERO;
    end else begin
      status <= next_status;
      fptr <= next_fptr;
      pc_high_buffer <= next_pchb;
      pc <= next_pc;
      push <= next_push;
      push_addr <= next_push_addr;
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (acc.wr && g0_hit) begin
      gpr0[g0_idx] <= acc.wdata;
    end
    if (acc.wr && g1_hit) begin
      gpr1[g1_idx] <= acc.wdata;
    end
  end

  sequence s_call;
    pcop.long_call_instr && !pcop.long_jump_instr;
  endsequence

  property p_pc_reset;
    @(posedge mclk) $rose(reset_n) |-> pc[7:0] == BDM_PCLO_RST;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("pc not zero");

  property p_step;
    @(posedge mclk) disable iff (!reset_n)
      pcop.step && !pcop.long_jump_instr && !pcop.long_call_instr &&
      !(rpage && acc.wr && ofs == BDM_OFS_PCLO) |=> pc == $past(pc) + 11'h001;
  endproperty
  a_step: assert property (p_step) else $error("pc no step");

  property p_jump;
    @(posedge mclk) disable iff (!reset_n)
      pcop.long_jump_instr |=> pc == $past(pcop.target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump bad");

  property p_call;
    @(posedge mclk) disable iff (!reset_n)
      s_call |=> push && push_addr == $past(pc) + 11'h001 &&
                 pc == $past(pcop.target);
  endproperty
  a_call: assert property (p_call) else $error("call bad");

  property p_aux_excl;
    @(posedge mclk) disable iff (!reset_n)
      (fpage_sel || spage_sel) |-> !sfr_sel && !g0_hit && !g1_hit;
  endproperty
  a_aux_excl: assert property (p_aux_excl) else $error("aux leak");

  property p_tread;
    @(posedge mclk) disable iff (!reset_n)
      rpage && acc.rd && !acc.indirect && acc.opcode_ofs == BDM_OFS_TMR
      |=> rdata == $past(tcount);
  endproperty
  a_tread: assert property (p_tread) else $error("timer read");

  property p_pclo_wr;
    @(posedge mclk) disable iff (!reset_n)
      rpage && acc.wr && ofs == BDM_OFS_PCLO && !pcop.long_jump_instr &&
      !pcop.long_call_instr |=> pc == {$past(pc_high_buffer), $past(acc.wdata)};
  endproperty
  a_pclo_wr: assert property (p_pclo_wr) else $error("pcl write");

  property p_gpr_alias;
    @(posedge mclk) disable iff (!reset_n)
      rpage && ofs > BDM_B1_TOP |-> g0_hit && !g1_hit;
  endproperty
  a_gpr_alias: assert property (p_gpr_alias) else $error("alias bad");

  sequence s_hole;
    rpage && (ofs == BDM_OFS_NONE7 || ofs == BDM_OFS_NONED ||
              ofs == BDM_OFS_NONE1D || ofs == BDM_OFS_NONE1E);
  endsequence

  property p_hole;
    @(posedge mclk) disable iff (!reset_n)
      s_hole |-> !sfr_sel ##1 rdata == BDM_ZERO;
  endproperty
  a_hole: assert property (p_hole) else $error("hole");

  property p_indirect_access_port;
    @(posedge mclk) disable iff (!reset_n)
      rpage && ofs == BDM_OFS_INDIRECT_ACCESS_PORT |=> rdata == BDM_ZERO;
  endproperty
  a_indirect_access_port: assert property (p_indirect_access_port) else $error("indirect_access_port");

  property p_pchb;
    @(posedge mclk) disable iff (!reset_n)
      rpage && acc.wr && ofs == BDM_OFS_PCHB && !pcop.step &&
      !pcop.long_jump_instr && !pcop.long_call_instr |=> pc == $past(pc);
  endproperty
  a_pchb: assert property (p_pchb) else $error("pchb");

  property p_bank1;
    @(posedge mclk) disable iff (!reset_n)
      rpage && ofs >= BDM_GPR_LO && ofs <= BDM_B1_TOP && bank[0]
      |-> g1_hit && !g0_hit;
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank1");
endmodule : bdm_map

// ==== hdl/bdm_pkg.sv ====
// Overview of operation
// - sfr offsets mirror to bank 0 always
// - gpr storage only bank0 20-7f, bank1 20-3f
// - upper banks alias into bank 0 or 1
// - aux pages only via dedicated instructions
// - aux pages ignore bank bits
// - indirect port redirects through file pointer
// - timer0 read returns live count
// - timer0 write replaces running count
// - timer0 source: inst clock, pin, low osc
// - pc low byte shows pc[7:0], resets zero
// - pc increments on each step, unless a long jump/call or a pc low write loads it
// - pc[10:8] from high buffer on pc low write, or from long jump/call target
// - long jump loads all 11 pc bits
// - long call loads pc, pushes pc+1
// - status bits 7:6 select bank
// - indirect offset from pointer bits 6:0
// - direct offset from opcode bits 6:0
package bdm_pkg;
  localparam int BDM_PC_W = 11;
  localparam logic [6:0] BDM_OFS_INDIRECT_ACCESS_PORT = 7'h00;
  localparam logic [6:0] BDM_OFS_TMR = 7'h01;
  localparam logic [6:0] BDM_OFS_PCLO = 7'h02;
  localparam logic [6:0] BDM_OFS_STAT = 7'h03;
  localparam logic [6:0] BDM_OFS_FPTR = 7'h04;
  localparam logic [6:0] BDM_OFS_PCHB = 7'h0a;
  localparam logic [6:0] BDM_OFS_NONE7 = 7'h07;
  localparam logic [6:0] BDM_OFS_NONED = 7'h0d;
  localparam logic [6:0] BDM_OFS_NONE1D = 7'h1d;
  localparam logic [6:0] BDM_OFS_NONE1E = 7'h1e;
  localparam logic [6:0] BDM_SFR_TOP = 7'h1f;
  localparam logic [6:0] BDM_GPR_LO = 7'h20;
  localparam logic [6:0] BDM_B1_TOP = 7'h3f;
  localparam logic [7:0] BDM_PCLO_RST = 8'h00;
  localparam logic [2:0] BDM_PCHB_RST = 3'h0;
  localparam logic [7:0] BDM_STAT_RST = 8'h18;
  localparam logic [7:0] BDM_ZERO = 8'h00;
  localparam logic [1:0] BDM_BANK1 = 2'h1;
  localparam logic [1:0] BDM_BANK3 = 2'h3;

  typedef enum logic [1:0] {
    BDM_SRC_INST = 2'b00,
    BDM_SRC_PIN = 2'b01,
    BDM_SRC_LOSC = 2'b10
  } bdm_tsrc_t;

  typedef enum logic [2:0] {
    BDM_SP_RPAGE = 3'b000,
    BDM_SP_FPAGE_WR = 3'b001,
    BDM_SP_FPAGE_RD = 3'b010,
    BDM_SP_SPAGE_WR = 3'b011,
    BDM_SP_SPAGE_RD = 3'b100
  } bdm_space_t;

  typedef struct packed {
    logic valid;
    bdm_space_t space;
    logic indirect;
    logic [6:0] opcode_ofs;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } bdm_acc_t;

  typedef struct packed {
    logic step;
    logic long_jump_instr;
    logic long_call_instr;
    logic [10:0] target;
  } bdm_pcop_t;
endpackage : bdm_pkg

// ==== hdl/bdm_timer0.sv ====
`timescale 1ns/10ps
module bdm_timer0
  import bdm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // tick sources
  input wire logic instruction_clock,
  input wire logic ext_timer0_clock_pin,
  input wire logic low_osc_tick,
  input wire bdm_pkg::bdm_tsrc_t src,
  // load port
  input wire logic load,
  input wire logic [7:0] load_data,
  // count
  output logic [7:0] count
);
  logic [7:0] next_count;
  logic tick;

  always_comb begin
    unique case (src)
      BDM_SRC_PIN: tick = ext_timer0_clock_pin;
      BDM_SRC_LOSC: tick = low_osc_tick;
      default: tick = instruction_clock;
    endcase
  end

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_data;
    end else if (tick) begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count <= BDM_ZERO;
    end else begin
      count <= next_count;
    end
  end

  property p_load;
    @(posedge mclk) disable iff (!reset_n)
      load |=> count == $past(load_data);
  endproperty
  a_load: assert property (p_load) else $error("timer load lost");
endmodule : bdm_timer0

// ==== sim/bdm_cpu_model.sv ====
`timescale 1ns/10ps
module bdm_cpu_model (
  // clock
  mclk,
  // requests toward the map
  acc,
  pcop
);
  import bdm_pkg::*;
  input wire logic mclk;
  output bdm_pkg::bdm_acc_t acc;
  output bdm_pkg::bdm_pcop_t pcop;
  initial begin
    acc = '0;
    pcop = '0;
  end
  // one access, held over its taking edge
  task automatic access(input bdm_space_t sp, input logic ind,
      input logic [6:0] o, input logic w, input logic [7:0] d);
    @(posedge mclk);
    #1;
    acc = '{1'b1, sp, ind, o, w, ~w, d};
    @(posedge mclk);
    #1;
    acc = '0;
  endtask : access
  // one program counter operation
  task automatic pc_op(input logic [2:0] k, input logic [10:0] t);
    @(posedge mclk);
    #1;
    pcop = {k, t};
    @(posedge mclk);
    #1;
    pcop = '0;
  endtask : pc_op
endmodule : bdm_cpu_model

// ==== sim/tb_banked_data_memory_map.sv ====
`timescale 1ns/10ps
module tb_banked_data_memory_map;
  import bdm_pkg::*;
  logic mclk, reset_n, ic, pin, losc, tmode, cfg, hit, fs, ss, xs, push;
  logic c_fs, c_ss, c_xs, un;
  logic [7:0] aux_rd, sfr_rd, rdata, d, e;
  logic [6:0] aofs, xofs, c_aofs, c_xofs, o;
  logic [10:0] pc, push_addr, t, old, mpc;
  logic [2:0] v;
  bdm_acc_t acc;
  bdm_pcop_t pcop;
  int err_count, checked, cnt, b, k;
  int mem[256];
  bdm_map dut (.mclk(mclk), .reset_n(reset_n), .acc(acc), .rdata(rdata),
    .fpage_sel(fs), .spage_sel(ss), .aux_ofs(aofs), .aux_rdata(aux_rd),
    .sfr_sel(xs), .sfr_ofs(xofs), .sfr_rdata(sfr_rd), .sfr_hit(hit),
    .pcop(pcop), .pc(pc), .push(push), .push_addr(push_addr),
    .instruction_clock(ic), .ext_timer0_clock_pin(pin),
    .low_osc_tick(losc), .timer0_mode_bits(tmode), .cfg_low_osc(cfg));
  bdm_cpu_model cpu (.mclk(mclk), .acc(acc), .pcop(pcop));
  always @(negedge mclk) if (acc.valid) begin
    {c_fs, c_ss, c_xs, c_aofs, c_xofs} = {fs, ss, xs, aofs, xofs};
  end
  task automatic chk(input string n, input logic [10:0] x,
      input logic [10:0] g);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] w);
    cpu.access(BDM_SP_RPAGE, 1'b0, a, 1'b1, w);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    cpu.access(BDM_SP_RPAGE, 1'b0, a, 1'b0, 8'h00);
  endtask : rd
  // bank 1 and 3 low half land in bank 1, all else in bank 0
  function automatic int ph(int bk, int a);
    return (a < 'h40 && bk[0]) ? a + 'h80 : a;
  endfunction : ph
  task automatic test_done;
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    {reset_n, ic, pin, losc, tmode, cfg, hit, aux_rd, sfr_rd} = '0;
    void'($urandom(79931));
    repeat (20) @(posedge mclk);
    #1 reset_n = 1;
    chk("pc", 0, pc);
    repeat (5) cpu.pc_op(3'b100, 11'h000);
    chk("pc", 5, pc);
    wr(BDM_OFS_PCHB, 8'h05);
    rd(BDM_OFS_PCHB);
    chk("pchb", 0, rdata);
    wr(BDM_OFS_PCLO, 8'h34);
    chk("pc", 11'h534, pc);
    rd(BDM_OFS_PCLO);
    chk("pcl", 8'h34, rdata);
    for (k = 0; k < 24; k++) begin
      t = 11'($urandom);
      old = pc;
      cpu.pc_op(k % 2 ? 3'b001 : 3'b010, t);
      mpc = t;
      chk("pc", t, pc);
      chk("push", k % 2, push);
      if (k % 2 == 1)
        chk("ret", old + 11'h1, push_addr);
    end
    for (k = 0; k < 3; k++) begin
      tmode = k != 0;
      cfg = k == 2;
      d = 8'($urandom);
      wr(BDM_OFS_TMR, d);
      cnt = 0;
      repeat (9) begin
        @(posedge mclk);
        #1;
        v = 3'($urandom);
        {losc, pin, ic} = v;
        cnt += v[k];
        @(posedge mclk);
        #1;
        {losc, pin, ic} = 3'h0;
      end
      rd(BDM_OFS_TMR);
      e = d + 8'(cnt);
      chk("tmr", e, rdata);
    end
    for (b = 0; b < 2; b++) begin
      wr(BDM_OFS_STAT, {b[1:0], 6'h18});
      for (k = 'h20; k < (b ? 'h40 : 'h80); k++) begin
        d = 8'($urandom);
        wr(7'(k), d);
        mem[ph(b, k)] = d;
      end
    end
    repeat (300) begin
      b = $urandom % 4;
      k = $urandom % 6;
      o = 7'($urandom_range('h7f, 'h20));
      d = 8'($urandom);
      wr(BDM_OFS_STAT, {b[1:0], 6'h18});
      if (k == 0) begin
        wr(o, d);
        mem[ph(b, o)] = d;
      end else if (k == 1) begin
        rd(o);
        chk("gpr", mem[ph(b, o)], rdata);
      end else if (k < 4) begin
        wr(BDM_OFS_FPTR, {d[7], o});
        if (k == 3) begin
          wr(BDM_OFS_INDIRECT_ACCESS_PORT, d);
          mem[ph(b, o)] = d;
          rd(BDM_OFS_INDIRECT_ACCESS_PORT);
        end else begin
          cpu.access(BDM_SP_RPAGE, 1'b1, BDM_OFS_TMR, 1'b0, 8'h00);
        end
        chk("ind", mem[ph(b, o)], rdata);
      end else if (k == 4) begin
        o = 7'($urandom_range('h1f, 'h05));
        if (o == BDM_OFS_PCHB)
          o = 7'h0b;
        hit = d[0];
        sfr_rd = 8'($urandom);
        un = o == BDM_OFS_NONE7 || o == BDM_OFS_NONED ||
             o == BDM_OFS_NONE1D || o == BDM_OFS_NONE1E;
        rd(o);
        chk("sfr", (hit && !un) ? sfr_rd : 8'h00, rdata);
        chk("sofs", {c_xs, c_fs, c_ss, c_xofs}, {!un, 2'b0, o});
        rd(BDM_OFS_PCLO);
        chk("pcl", mpc[7:0], rdata);
      end else begin
        v = 3'($urandom_range(4, 1));
        aux_rd = 8'($urandom);
        cpu.access(bdm_space_t'(v), 1'b0, o, v[0], d);
        chk("aux", {c_fs, c_ss, c_aofs}, {v < 3, v > 2, o});
        if (!v[0])
          chk("auxd", aux_rd, rdata);
      end
    end
    @(posedge mclk);
    #1 reset_n = 0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1;
    chk("pc", 0, pc);
    rd(BDM_OFS_PCLO);
    chk("pcl", 0, rdata);
    test_done();
  end
endmodule : tb_banked_data_memory_map
